// >>> design/vac_pkg.sv
// Constants for the VCO tune and converter calibration control block.
// Assumes a 40 MHz register clock and a 32-bit classic Wishbone slave port.
package vac_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_PS      = 25000;
	localparam int SETTLE_UNIT_NS     = 1000;
	localparam int SETTLE_UNIT_CYCLES =
		(SETTLE_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_TRIM        = 8'h59;
	localparam logic [7:0] IDX_PLL_RESET   = 8'h5c;
	localparam logic [7:0] IDX_TUNE_CTRL   = 8'h5d;
	localparam logic [7:0] IDX_TUNE_STATUS = 8'h5e;
	localparam logic [7:0] IDX_CAL_ENABLE  = 8'h61;
	localparam logic [7:0] IDX_LINK_ENABLE = 8'h70;
	localparam int         ADR_WIDTH       = 10;

	// ==========================================================
	// Field positions and widths
	localparam int TRIM_WIDTH     = 7;
	localparam int STL_LSB        = 4;
	localparam int STL_WIDTH      = 3;
	localparam int TUNE_EN_BIT    = 0;
	localparam int DONE_BIT       = 0;
	localparam int PLL_RESET_BIT  = 0;
	localparam int CAL_RUN_BIT    = 0;
	localparam int LINK_EN_BIT    = 0;

	// ==========================================================
	// Reset values
	localparam logic [6:0] RST_TRIM      = 7'h00;
	localparam logic       RST_PLL_RESET = 1'h0;
	localparam logic [2:0] RST_STL       = 3'h4;
	localparam logic       RST_TUNE_EN   = 1'h0;
	localparam logic       RST_DONE      = 1'h0;
	localparam logic       RST_CAL_RUN   = 1'h1;
	localparam logic       RST_LINK_EN   = 1'h0;

	// ==========================================================
	// Tune engine states
	typedef enum logic [1:0] {
		VAC_IDLE,
		VAC_STEP,
		VAC_SETTLE,
		VAC_DONE
	} vac_state_type;

endpackage : vac_pkg

// >>> design/vac_settle_timer.sv
// Down counter that times the PLL settling after each trim bit the engine tries.
// Assumes a synchronous start pulse and a reset already synchronised.
`timescale 1ns/1ps
module vac_settle_timer #(
	parameter int WIDTH = 12
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             start_in,
	input  wire logic             abort_in,
	input  wire logic [WIDTH-1:0] load_in,
	output logic                  expired_out
);

	if (WIDTH < 2) begin : g_width_check
		$error("vac_settle_timer: WIDTH too small");
	end

	// ==========================================================
	// Counter
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             busy;
	logic             next_busy;

	always_comb begin
		next_count  = count;
		next_busy   = busy;
		expired_out = busy && (count == '0);
		if (abort_in) begin
			next_busy  = 1'b0;
			next_count = '0;
		end else if (start_in) begin
			next_busy  = 1'b1;
			next_count = load_in;
		end else if (expired_out) begin
			next_busy = 1'b0;
		end else if (busy) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= '0;
			busy  <= 1'b0;
		end else begin
			count <= next_count;
			busy  <= next_busy;
		end
	end

endmodule : vac_settle_timer

// >>> design/vac_calibration_control.sv
// VCO tune engine and converter calibration run control, Wishbone slave.
// Assumes CLK_IN at 40 MHz, a VCO comparator input synchronous to it.
//
// Behaviour
// - Settle field, reset 4, longer wait per value
// - Engine starts when PLL reset written 0
// - Engine searches trim to centre VCO frequency
// - Done reads 1 after run or skip
// - Run bit, reset 1, low holds calibration
// - Run bit low resets digital and link dividers
// - Seven-bit trim, engine-set, software readable, writable only while the engine is idle or done
`timescale 1ns/1ps
module vac_calibration_control #(
	parameter int SETTLE_UNIT = vac_pkg::SETTLE_UNIT_CYCLES,
	parameter int TIMER_WIDTH = 12
) (
	input  wire logic        CLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [9:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	input  wire logic        VCO_FAST_IN,
	output logic      [6:0]  VCO_TRIM_OUT,
	output logic             PLL_CAL_RESET_OUT,
	output logic             VCO_TUNE_BUSY_OUT,
	output logic             CAL_RUN_OUT,
	output logic             DIVIDER_RESET_OUT,
	output logic             SERIAL_LINK_ENABLE_OUT
);

	if (SETTLE_UNIT < 1 ||
		SETTLE_UNIT * 8 >= (1 << TIMER_WIDTH)) begin : g_unit_check
		$error("vac_calibration_control: settle unit out of range");
	end

	// ==========================================================
	// Reset synchroniser
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================================
	// Bus decode
	logic        bus_req;
	logic        wr_commit;
	logic [7:0]  bus_idx;
	logic        lane0_wr;
	logic [7:0]  wr_byte;

	assign bus_req   = WB_CYC_IN && WB_STB_IN;
	assign bus_idx   = WB_ADR_IN[9:2];
	assign wr_commit = bus_req && WB_ACK_OUT && WB_WE_IN;
	assign lane0_wr  = wr_commit && WB_SEL_IN[0];
	assign wr_byte   = WB_DAT_IN[7:0];

	// ==========================================================
	// Software registers
	logic [2:0] settle_time;
	logic       tune_enable;
	logic       pll_cal_reset;
	logic       cal_run;
	logic       link_enable;
	logic [2:0] next_settle_time;
	logic       next_tune_enable;
	logic       next_pll_cal_reset;
	logic       next_cal_run;
	logic       next_link_enable;

	always_comb begin
		next_settle_time   = settle_time;
		next_tune_enable   = tune_enable;
		next_pll_cal_reset = pll_cal_reset;
		next_cal_run       = cal_run;
		next_link_enable   = link_enable;
		if (lane0_wr) begin
			unique case (bus_idx)
				vac_pkg::IDX_TUNE_CTRL: begin
					next_settle_time = wr_byte[vac_pkg::STL_LSB +:
						vac_pkg::STL_WIDTH];
					next_tune_enable = wr_byte[vac_pkg::TUNE_EN_BIT];
				end
				vac_pkg::IDX_PLL_RESET: begin
					next_pll_cal_reset = wr_byte[vac_pkg::PLL_RESET_BIT];
				end
				vac_pkg::IDX_CAL_ENABLE: begin
					next_cal_run = wr_byte[vac_pkg::CAL_RUN_BIT];
				end
				vac_pkg::IDX_LINK_ENABLE: begin
					next_link_enable = wr_byte[vac_pkg::LINK_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			settle_time   <= vac_pkg::RST_STL;
			tune_enable   <= vac_pkg::RST_TUNE_EN;
			pll_cal_reset <= vac_pkg::RST_PLL_RESET;
			cal_run       <= vac_pkg::RST_CAL_RUN;
			link_enable   <= vac_pkg::RST_LINK_EN;
		end else begin
			settle_time   <= next_settle_time;
			tune_enable   <= next_tune_enable;
			pll_cal_reset <= next_pll_cal_reset;
			cal_run       <= next_cal_run;
			link_enable   <= next_link_enable;
		end
	end

	// ==========================================================
	// Tune start detection
	logic tune_start;

	// Write of 0 over a set reset bit launches the engine
	assign tune_start = pll_cal_reset && !next_pll_cal_reset;

	// ==========================================================
	// Settle timer
	logic                   timer_start;
	logic                   timer_expired;
	logic [TIMER_WIDTH-1:0] settle_load;
	logic [TIMER_WIDTH-1:0] settle_unit_w;

	assign settle_unit_w = TIMER_WIDTH'(SETTLE_UNIT);
	// Value n waits (n + 1) units, so the load is one cycle less
	assign settle_load = TIMER_WIDTH'(({1'b0, settle_time} + 4'h1)
		* settle_unit_w - 1'b1);

	vac_settle_timer #(
		.WIDTH       (TIMER_WIDTH)
	) u_settle (
		.clk_in      (CLK_IN),
		.rst_n_in    (rst_n),
		.start_in    (timer_start),
		.abort_in    (pll_cal_reset),
		.load_in     (settle_load),
		.expired_out (timer_expired)
	);

	// ==========================================================
	// Tune engine
	vac_pkg::vac_state_type state;
	vac_pkg::vac_state_type next_state;
	logic [6:0] trim;
	logic [6:0] next_trim;
	logic [6:0] probe;
	logic [6:0] next_probe;
	logic       done;
	logic       next_done;

	always_comb begin
		next_state  = state;
		next_trim   = trim;
		next_probe  = probe;
		next_done   = done;
		timer_start = 1'b0;
		// Software trim write, ignored while a run owns it
		if (lane0_wr && bus_idx == vac_pkg::IDX_TRIM &&
			(state == vac_pkg::VAC_IDLE ||
			state == vac_pkg::VAC_DONE)) begin
			next_trim = wr_byte[vac_pkg::TRIM_WIDTH-1:0];
		end
		if (pll_cal_reset && !tune_start) begin
			next_state = vac_pkg::VAC_IDLE;
			next_done  = 1'b0;
		end else begin
			unique case (state)
				vac_pkg::VAC_IDLE: begin
					if (tune_start && tune_enable) begin
						next_state = vac_pkg::VAC_STEP;
						next_probe = 7'h40;
						next_trim  = 7'h00;
						next_done  = 1'b0;
					end else if (tune_start) begin
						next_state = vac_pkg::VAC_DONE;
						next_done  = 1'b1;
					end
				end
				vac_pkg::VAC_STEP: begin
					// Try the next bit, then let the PLL settle
					next_trim   = trim | probe;
					timer_start = 1'b1;
					next_state  = vac_pkg::VAC_SETTLE;
				end
				vac_pkg::VAC_SETTLE: begin
					if (timer_expired) begin
						if (VCO_FAST_IN) begin
							next_trim = trim & ~probe;
						end
						next_probe = probe >> 1;
						if (probe == 7'h01) begin
							next_state = vac_pkg::VAC_DONE;
							next_done  = 1'b1;
						end else begin
							next_state = vac_pkg::VAC_STEP;
						end
					end
				end
				vac_pkg::VAC_DONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state <= vac_pkg::VAC_IDLE;
			trim  <= vac_pkg::RST_TRIM;
			probe <= 7'h00;
			done  <= vac_pkg::RST_DONE;
		end else begin
			state <= next_state;
			trim  <= next_trim;
			probe <= next_probe;
			done  <= next_done;
		end
	end

	// ==========================================================
	// Read mux and acknowledge
	logic [7:0]  rd_byte;
	logic [31:0] next_dat;
	logic        next_ack;

	always_comb begin
		rd_byte = 8'h00;
		unique case (bus_idx)
			vac_pkg::IDX_TRIM: begin
				rd_byte[vac_pkg::TRIM_WIDTH-1:0] = trim;
			end
			vac_pkg::IDX_PLL_RESET: begin
				rd_byte[vac_pkg::PLL_RESET_BIT] = pll_cal_reset;
			end
			vac_pkg::IDX_TUNE_CTRL: begin
				rd_byte[vac_pkg::STL_LSB +: vac_pkg::STL_WIDTH] =
					settle_time;
				rd_byte[vac_pkg::TUNE_EN_BIT] = tune_enable;
			end
			vac_pkg::IDX_TUNE_STATUS: begin
				rd_byte[vac_pkg::DONE_BIT] = done;
			end
			vac_pkg::IDX_CAL_ENABLE: begin
				rd_byte[vac_pkg::CAL_RUN_BIT] = cal_run;
			end
			vac_pkg::IDX_LINK_ENABLE: begin
				rd_byte[vac_pkg::LINK_EN_BIT] = link_enable;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
		next_ack = bus_req && !WB_ACK_OUT;
		next_dat = WB_DAT_OUT;
		if (next_ack) begin
			next_dat = {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else begin
			WB_ACK_OUT <= next_ack;
			WB_DAT_OUT <= next_dat;
		end
	end

	// ==========================================================
	// Outputs to the analog and clocking logic
	logic next_div_reset;

	assign next_div_reset = !cal_run;

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			DIVIDER_RESET_OUT <= !vac_pkg::RST_CAL_RUN;
		end else begin
			DIVIDER_RESET_OUT <= next_div_reset;
		end
	end

	assign VCO_TRIM_OUT           = trim;
	assign PLL_CAL_RESET_OUT      = pll_cal_reset;
	assign CAL_RUN_OUT            = cal_run;
	assign SERIAL_LINK_ENABLE_OUT = link_enable;
	assign VCO_TUNE_BUSY_OUT      = (state == vac_pkg::VAC_STEP) ||
		(state == vac_pkg::VAC_SETTLE);

endmodule : vac_calibration_control

// >>> bench/vac_calibration_control_props.sv
// Checker for the VCO tune and calibration control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module vac_calibration_control_props (
	input wire logic        CLK_IN,
	input wire logic        ARST_N_IN,
	input wire logic        WB_CYC_IN,
	input wire logic        WB_STB_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic        WB_ACK_OUT,
	input wire logic [6:0]  VCO_TRIM_OUT,
	input wire logic        PLL_CAL_RESET_OUT,
	input wire logic        VCO_TUNE_BUSY_OUT,
	input wire logic        CAL_RUN_OUT,
	input wire logic        DIVIDER_RESET_OUT,
	input wire logic        SERIAL_LINK_ENABLE_OUT
);
	// ==========
	// Properties
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire logic req = WB_CYC_IN && WB_STB_IN;

	ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	ack_time_a: assert property (req && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack missing");
	rd_hold_a: assert property (WB_ACK_OUT ##1 !req |-> $stable(WB_DAT_OUT))
		else $error("read data not held");
	hi_zero_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
		else $error("upper read bits set");
	run_div_a: assert property (CAL_RUN_OUT |=> !DIVIDER_RESET_OUT)
		else $error("dividers held while running");
	hold_div_a: assert property (!CAL_RUN_OUT |=> DIVIDER_RESET_OUT)
		else $error("dividers free while held");
	regs_hold_a: assert property (!WB_ACK_OUT |=>
		$stable({CAL_RUN_OUT, SERIAL_LINK_ENABLE_OUT, PLL_CAL_RESET_OUT}))
		else $error("control bit changed without write");
	idle_quiet_a: assert property (PLL_CAL_RESET_OUT [*2] |->
		!VCO_TUNE_BUSY_OUT)
		else $error("engine busy under pll reset");
	start_gate_a: assert property ($rose(VCO_TUNE_BUSY_OUT) |->
		!PLL_CAL_RESET_OUT)
		else $error("engine started under pll reset");
	trim_still_a: assert property (!WB_ACK_OUT && !VCO_TUNE_BUSY_OUT
		##1 !VCO_TUNE_BUSY_OUT |-> $stable(VCO_TRIM_OUT))
		else $error("trim moved while idle");

	cover property ($rose(VCO_TUNE_BUSY_OUT));
	cover property ($fell(CAL_RUN_OUT));
	cover property (WB_ACK_OUT && VCO_TUNE_BUSY_OUT);
endmodule : vac_calibration_control_props

bind vac_calibration_control vac_calibration_control_props props_i (
	.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
	.WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
	.WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.VCO_TRIM_OUT(VCO_TRIM_OUT), .PLL_CAL_RESET_OUT(PLL_CAL_RESET_OUT),
	.VCO_TUNE_BUSY_OUT(VCO_TUNE_BUSY_OUT), .CAL_RUN_OUT(CAL_RUN_OUT),
	.DIVIDER_RESET_OUT(DIVIDER_RESET_OUT),
	.SERIAL_LINK_ENABLE_OUT(SERIAL_LINK_ENABLE_OUT));

// >>> bench/vac_calibration_control_tb.sv
// Testbench for the VCO tune and calibration control block.
// Assumes the checker file is compiled with it and bound to the design.
`timescale 1ns/1ps
module vac_calibration_control_tb;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fast = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] dat = 32'h0, rdat, q;
	logic        ack, pll, busy, run, divr, link;
	logic [6:0]  trim, target = 7'h00;
	int          bad_count = 0, cmp_count = 0, ticks = 0, t0, d0;
	logic [7:0]  idx [7] = '{8'h59, 8'h5c, 8'h5d, 8'h5e, 8'h61, 8'h70, 8'h00};
	logic [7:0]  rst [7] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h00};
	wire logic [31:0] pv = {27'h0, divr, run, link, pll, busy};

	// ==========
	// Design, clock and comparator plant
	vac_calibration_control #(.SETTLE_UNIT(2)) vac_calibration_control_i (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(dat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .VCO_FAST_IN(fast),
		.VCO_TRIM_OUT(trim), .PLL_CAL_RESET_OUT(pll),
		.VCO_TUNE_BUSY_OUT(busy), .CAL_RUN_OUT(run),
		.DIVIDER_RESET_OUT(divr), .SERIAL_LINK_ENABLE_OUT(link));
	always #12.5 clk = ~clk;
	always @(posedge clk) fast <= trim > target;
	always @(posedge clk) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			bad_count++;
			end_sim;
		end
	end

	// ==========
	// Tasks
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, i, 2'b00, 24'h0, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask : bus

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tune(input logic [2:0] s, input logic e, input logic [6:0] g);
		target <= g;
		bus(1, 8'h5c, 8'h01);
		bus(0, 8'h5e, 8'h00);
		chk(q, 32'h0);
		bus(1, 8'h5d, {1'b0, s, 3'b000, e});
		bus(1, 8'h5c, 8'h00);
		t0 = ticks;
		if (e) bus(1, 8'h59, 8'h7f);
		q = 32'h0;
		for (int n = 0; n < 400 && q[0] !== 1'b1; n++) begin
			bus(0, 8'h5e, 8'h00);
		end
		t0 = ticks - t0;
		chk(q, 32'h1);
		bus(0, 8'h59, 8'h00);
		chk(q, {25'h0, g});
	endtask : tune

	task automatic end_sim;
		$display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// ==========
	// Tests
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pv, 32'h08);
		bus(1, 8'h00, 8'hff);
		foreach (idx[k]) begin
			bus(0, idx[k], 8'h00);
			chk(q, {24'h0, rst[k]});
		end
		$display("reset test done");
		tune(3'h4, 1'b0, 7'h00);
		tune(3'h0, 1'b1, 7'h5a);
		d0 = t0;
		tune(3'h7, 1'b1, 7'h25);
		chk({31'h0, t0 > d0}, 32'h1);
		$display("tune test done");
		bus(1, 8'h5c, 8'h01);
		bus(1, 8'h5d, 8'h71);
		bus(1, 8'h5c, 8'h00);
		bus(0, 8'h5e, 8'h00);
		chk(q, 32'h0);
		bus(1, 8'h5c, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, busy}, 32'h0);
		bus(1, 8'h59, 8'h33);
		bus(0, 8'h59, 8'h00);
		chk(q, 32'h33);
		$display("abort test done");
		bus(1, 8'h70, 8'h01);
		@(posedge clk);
		chk(pv, 32'h0e);
		bus(1, 8'h70, 8'h00);
		bus(1, 8'h61, 8'h00);
		bus(0, 8'h61, 8'h00);
		chk(q, 32'h0);
		chk(pv, 32'h12);
		bus(1, 8'h61, 8'h01);
		bus(0, 8'h61, 8'h00);
		chk(q, 32'h1);
		chk(pv, 32'h0a);
		$display("run test done");
		end_sim;
	end
endmodule : vac_calibration_control_tb
